// ### shared/wake_defines.svh
// Constants of the post-configuration wake-up sequencer: sequence numbers,
// phase codes and reset values. Assumes inclusion by bare name only.
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH

// Sequence used when none is chosen and wake-up does not wait on the pin.
`define WAKE_SEQ_DEFAULT_INTERNAL 5'h15
// Sequence used when none is chosen and wake-up waits on the pin.
`define WAKE_SEQ_DEFAULT_EXTERNAL 5'h04
// Highest sequence accepted without the external wait.
`define WAKE_SEQ_MAX_INTERNAL 5'h19
// Highest sequence accepted with the external wait.
`define WAKE_SEQ_MAX_EXTERNAL 5'h07
// Selection code meaning that no sequence was chosen.
`define WAKE_SEQ_NONE 5'h00
// Phase codes for the four wake phases.
`define PHASE_ZERO 2'h0
`define PHASE_ONE 2'h1
`define PHASE_TWO 2'h2
`define PHASE_THREE 2'h3
// Reset values of the global controls: outputs off, writes and set/reset held.
`define RST_GLOBAL_OUTPUT_ENABLE 1'h0
`define RST_GLOBAL_WRITE_INHIBIT 1'h1
`define RST_GLOBAL_SET_RESET 1'h1
// Readback lock is off out of reset.
`define RST_READBACK_LOCK 1'h0

`endif

// ### shared/wake_pkg.sv
// Types shared by the wake-up sequencer and its start-up clock picker.
// Assumes the constants header is compiled alongside.
package wake_pkg;

  // Index of one wake phase, zero to three.
  typedef logic [1:0] phase_t;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PHASE,
    ST_HOLD,
    ST_USER
  } wake_state_e;

  // Phase in which each of the four controlled items is released.
  typedef struct packed {
    phase_t completion_pin;
    phase_t output_enable;
    phase_t write_inhibit;
    phase_t set_reset;
  } wake_plan_s;

  // Options captured once configuration has finished.
  typedef struct packed {
    logic readback_lock_option;
    logic external_completion_wait;
    logic completion_pin_open_drain;
    logic unused_input_shutoff;
  } wake_options_s;

  // Which clock paces the start-up phases.
  typedef enum logic [1:0] {
    SRC_CONFIG_PORT,
    SRC_JTAG,
    SRC_USER
  } startup_src_e;

endpackage

// ### hw/startup_tick_gen.sv
// Picks the clock that paces the start-up phases and turns its rising edge
// into a one-cycle tick. Assumes all candidate clocks are slow, synchronous
// levels sampled on the system clock.
`timescale 1ns/1ps
module startup_tick_gen (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic config_port_clock_in,
  input wire logic jtag_clock_in,
  input wire logic user_startup_clock_in,
  input wire wake_pkg::startup_src_e src_in,
  output logic tick_out
);

  // Level of the selected clock, and its value one cycle earlier.
  logic sel_level;
  logic prev_reg;

  // Choose the pacing clock; a user clock overrides both defaults.
  always_comb begin
    case (src_in)
      wake_pkg::SRC_JTAG: sel_level = jtag_clock_in;
      wake_pkg::SRC_USER: sel_level = user_startup_clock_in;
      default: sel_level = config_port_clock_in;
    endcase
  end

  // Rising-edge detect; one tick per start-up clock cycle.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prev_reg <= 1'h0;
      tick_out <= 1'h0;
    end else begin
      prev_reg <= sel_level;
      tick_out <= sel_level & ~prev_reg;
    end
  end

endmodule // startup_tick_gen

// ### hw/wake_sequencer.sv
// Post-configuration wake-up sequencer: steps the selected sequence through
// four phases, releasing the global controls and the completion pin, and
// gates readback and unused input buffers. Assumes synchronous inputs and a
// pull-up on the completion pin outside the device.
`timescale 1ns/1ps
`include "wake_defines.svh"

// Functional notes
// - Lock on refuses all general content readback.
// - Identification area always readable over JTAG.
// - Readback lock defaults to off.
// - Sequence times three controls plus completion pin.
// - Completion pin driven after config, before user.
// - Default sequence depends on external wait option.
// - No wait: accept 1-25, default 21.
// - Wait: accept 1-7, default 4.
// - Pace by port clock, or JTAG clock.
// - Attached user clock overrides default pacing clock.
// - Shutoff option disables every unused input buffer.
// - Each sequence maps items to phases 0-3.
// - With wait, hold until pin samples high.
// - Without wait, start on internal bit; ignore pin.
// - Pin low means not ready; high when finished.
module wake_sequencer #(
  parameter int NUM_INPUTS = 8
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CONFIG_DONE_IN,
  input wire logic LOADED_VIA_JTAG_IN,
  input wire logic USER_CLOCK_ATTACHED_IN,
  input wire logic CONFIG_PORT_CLOCK_IN,
  input wire logic JTAG_CLOCK_IN,
  input wire logic USER_STARTUP_CLOCK_IN,
  input wire logic [4:0] WAKE_SEQ_SELECT_IN,
  input wire logic READBACK_LOCK_OPTION_IN,
  input wire logic EXTERNAL_COMPLETION_WAIT_IN,
  input wire logic COMPLETION_PIN_OPEN_DRAIN_IN,
  input wire logic UNUSED_INPUT_SHUTOFF_IN,
  input wire logic [NUM_INPUTS-1:0] INPUT_USED_IN,
  input wire logic COMPLETION_PIN_IN,
  input wire logic RB_CONFIG_PORT_REQ_IN,
  input wire logic RB_JTAG_REQ_IN,
  input wire logic RB_ID_REQ_IN,
  output logic COMPLETION_PIN_OUT,
  output logic COMPLETION_PIN_OE_OUT,
  output logic GLOBAL_OUTPUT_ENABLE_OUT,
  output logic GLOBAL_WRITE_INHIBIT_OUT,
  output logic GLOBAL_SET_RESET_OUT,
  output logic USER_MODE_OUT,
  output logic [1:0] WAKE_PHASE_OUT,
  output logic [4:0] WAKE_SEQ_ACTIVE_OUT,
  output logic WAKE_SEQ_REJECTED_OUT,
  output logic RB_CONFIG_PORT_GRANT_OUT,
  output logic RB_JTAG_GRANT_OUT,
  output logic RB_ID_GRANT_OUT,
  output logic RB_REFUSED_OUT,
  output logic [NUM_INPUTS-1:0] INPUT_BUF_EN_OUT
);

  // Release phase of each item for a given sequence number.
  function automatic wake_pkg::wake_plan_s plan_of(input logic [4:0] seq);
    wake_pkg::wake_plan_s p;
    p = '{`PHASE_THREE, `PHASE_ONE, `PHASE_TWO, `PHASE_TWO};
    case (seq)
      5'h01: p = '{`PHASE_ZERO, `PHASE_ONE, `PHASE_ONE, `PHASE_ONE};
      5'h02: p = '{`PHASE_ZERO, `PHASE_TWO, `PHASE_TWO, `PHASE_TWO};
      5'h03: p = '{`PHASE_ZERO, `PHASE_THREE, `PHASE_THREE, `PHASE_THREE};
      5'h04: p = '{`PHASE_ZERO, `PHASE_ONE, `PHASE_TWO, `PHASE_TWO};
      5'h05: p = '{`PHASE_ZERO, `PHASE_ONE, `PHASE_THREE, `PHASE_THREE};
      5'h06: p = '{`PHASE_ZERO, `PHASE_ONE, `PHASE_TWO, `PHASE_THREE};
      5'h07: p = '{`PHASE_ZERO, `PHASE_ONE, `PHASE_THREE, `PHASE_TWO};
      5'h08: p = '{`PHASE_ONE, `PHASE_TWO, `PHASE_TWO, `PHASE_TWO};
      5'h09: p = '{`PHASE_ONE, `PHASE_THREE, `PHASE_THREE, `PHASE_THREE};
      5'h0A: p = '{`PHASE_ONE, `PHASE_THREE, `PHASE_TWO, `PHASE_TWO};
      5'h0B: p = '{`PHASE_ONE, `PHASE_TWO, `PHASE_THREE, `PHASE_THREE};
      5'h0C: p = '{`PHASE_TWO, `PHASE_THREE, `PHASE_THREE, `PHASE_THREE};
      5'h0D: p = '{`PHASE_TWO, `PHASE_ONE, `PHASE_ONE, `PHASE_ONE};
      5'h0E: p = '{`PHASE_TWO, `PHASE_ONE, `PHASE_THREE, `PHASE_THREE};
      5'h0F: p = '{`PHASE_TWO, `PHASE_ONE, `PHASE_ONE, `PHASE_THREE};
      5'h10: p = '{`PHASE_TWO, `PHASE_THREE, `PHASE_ONE, `PHASE_THREE};
      5'h11: p = '{`PHASE_TWO, `PHASE_THREE, `PHASE_ONE, `PHASE_ONE};
      5'h12: p = '{`PHASE_TWO, `PHASE_ONE, `PHASE_THREE, `PHASE_ONE};
      5'h13: p = '{`PHASE_THREE, `PHASE_TWO, `PHASE_TWO, `PHASE_TWO};
      5'h14: p = '{`PHASE_THREE, `PHASE_ONE, `PHASE_ONE, `PHASE_ONE};
      5'h15: p = '{`PHASE_THREE, `PHASE_ONE, `PHASE_TWO, `PHASE_TWO};
      5'h16: p = '{`PHASE_THREE, `PHASE_ONE, `PHASE_ONE, `PHASE_TWO};
      5'h17: p = '{`PHASE_THREE, `PHASE_TWO, `PHASE_ONE, `PHASE_TWO};
      5'h18: p = '{`PHASE_THREE, `PHASE_TWO, `PHASE_ONE, `PHASE_ONE};
      5'h19: p = '{`PHASE_THREE, `PHASE_ONE, `PHASE_TWO, `PHASE_ONE};
      default: p = '{`PHASE_THREE, `PHASE_ONE, `PHASE_TWO, `PHASE_TWO};
    endcase
    return p;
  endfunction

  // Sequencer state and the phase to be applied on the next tick.
  wake_pkg::wake_state_e state_reg;
  wake_pkg::phase_t phase_reg;
  // Options frozen when the internal completion bit is seen.
  wake_pkg::wake_options_s opt_reg;
  // Sequence actually in use, and its release plan.
  logic [4:0] seq_reg;
  wake_pkg::wake_plan_s plan;
  // Sticky release flags of the four items.
  logic pin_released_reg;
  logic oe_released_reg;
  logic wi_released_reg;
  logic sr_released_reg;
  // Pacing tick and the start-up clock source.
  logic tick;
  wake_pkg::startup_src_e src;
  // High on the tick that applies the current phase.
  logic apply_now;
  // Resolved sequence for the options presented at start.
  logic [4:0] seq_next;
  logic seq_rejected_next;

  // A user clock wins over the load path's own clock.
  always_comb begin
    if (USER_CLOCK_ATTACHED_IN) begin
      src = wake_pkg::SRC_USER;
    end else if (LOADED_VIA_JTAG_IN) begin
      src = wake_pkg::SRC_JTAG;
    end else begin
      src = wake_pkg::SRC_CONFIG_PORT;
    end
  end

  // Start-up clock picker and edge detector.
  startup_tick_gen u_tick (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .config_port_clock_in(CONFIG_PORT_CLOCK_IN),
    .jtag_clock_in(JTAG_CLOCK_IN),
    .user_startup_clock_in(USER_STARTUP_CLOCK_IN),
    .src_in(src),
    .tick_out(tick)
  );

  // Resolve the selection: none chosen or out of range falls back to the
  // default of the wait option. Rejecting rather than clamping keeps a bad
  // selection from silently picking a neighbouring timing.
  always_comb begin
    seq_rejected_next = 1'h0;
    if (EXTERNAL_COMPLETION_WAIT_IN) begin
      seq_next = `WAKE_SEQ_DEFAULT_EXTERNAL;
      if (WAKE_SEQ_SELECT_IN > `WAKE_SEQ_MAX_EXTERNAL) begin
        seq_rejected_next = 1'h1;
      end else if (WAKE_SEQ_SELECT_IN != `WAKE_SEQ_NONE) begin
        seq_next = WAKE_SEQ_SELECT_IN;
      end
    end else begin
      seq_next = `WAKE_SEQ_DEFAULT_INTERNAL;
      if (WAKE_SEQ_SELECT_IN > `WAKE_SEQ_MAX_INTERNAL) begin
        seq_rejected_next = 1'h1;
      end else if (WAKE_SEQ_SELECT_IN != `WAKE_SEQ_NONE) begin
        seq_next = WAKE_SEQ_SELECT_IN;
      end
    end
  end

  assign plan = plan_of(seq_reg);
  assign apply_now = (state_reg == wake_pkg::ST_PHASE) && tick;

  // Capture options and the sequence once, when configuration completes, so
  // that a change on the option pins cannot reshape a sequence in flight.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      opt_reg <= '{`RST_READBACK_LOCK, 1'h0, 1'h1, 1'h0};
      seq_reg <= `WAKE_SEQ_DEFAULT_INTERNAL;
      WAKE_SEQ_REJECTED_OUT <= 1'h0;
    end else if (state_reg == wake_pkg::ST_IDLE && CONFIG_DONE_IN) begin
      opt_reg.readback_lock_option <= READBACK_LOCK_OPTION_IN;
      opt_reg.external_completion_wait <= EXTERNAL_COMPLETION_WAIT_IN;
      // Waiting on the pin forces open drain so chained parts do not fight.
      opt_reg.completion_pin_open_drain <= COMPLETION_PIN_OPEN_DRAIN_IN |
                                           EXTERNAL_COMPLETION_WAIT_IN;
      opt_reg.unused_input_shutoff <= UNUSED_INPUT_SHUTOFF_IN;
      seq_reg <= seq_next;
      WAKE_SEQ_REJECTED_OUT <= seq_rejected_next;
    end
  end

  // Phase stepping. The internal completion bit starts the sequence; with
  // the external wait on, phase zero runs and the rest waits for the pin.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      state_reg <= wake_pkg::ST_IDLE;
      phase_reg <= `PHASE_ZERO;
    end else begin
      case (state_reg)
        wake_pkg::ST_IDLE: begin
          if (CONFIG_DONE_IN) begin
            state_reg <= wake_pkg::ST_PHASE;
            phase_reg <= `PHASE_ZERO;
          end
        end
        wake_pkg::ST_PHASE: begin
          if (tick) begin
            if (phase_reg == `PHASE_THREE) begin
              state_reg <= wake_pkg::ST_USER;
            end else if (phase_reg == `PHASE_ZERO && opt_reg.external_completion_wait) begin
              state_reg <= wake_pkg::ST_HOLD;
            end else begin
              phase_reg <= phase_reg + 2'h1;
            end
          end
        end
        wake_pkg::ST_HOLD: begin
          // Pin high means every party on it is ready.
          if (COMPLETION_PIN_IN) begin
            state_reg <= wake_pkg::ST_PHASE;
            phase_reg <= `PHASE_ONE;
          end
        end
        wake_pkg::ST_USER: begin
          state_reg <= wake_pkg::ST_USER;
        end
        default: begin
          state_reg <= wake_pkg::ST_IDLE;
          phase_reg <= `PHASE_ZERO;
        end
      endcase
    end
  end

  // Sticky releases; items of one phase flip on the same tick.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      pin_released_reg <= 1'h0;
      oe_released_reg <= 1'h0;
      wi_released_reg <= 1'h0;
      sr_released_reg <= 1'h0;
    end else if (apply_now) begin
      if (plan.completion_pin == phase_reg) pin_released_reg <= 1'h1;
      if (plan.output_enable == phase_reg) oe_released_reg <= 1'h1;
      if (plan.write_inhibit == phase_reg) wi_released_reg <= 1'h1;
      if (plan.set_reset == phase_reg) sr_released_reg <= 1'h1;
    end
  end

  // Global controls and status outputs, one flop each; the controls one cycle
  // after the release flags, the status one cycle after its registers.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      GLOBAL_OUTPUT_ENABLE_OUT <= `RST_GLOBAL_OUTPUT_ENABLE;
      GLOBAL_WRITE_INHIBIT_OUT <= `RST_GLOBAL_WRITE_INHIBIT;
      GLOBAL_SET_RESET_OUT <= `RST_GLOBAL_SET_RESET;
      USER_MODE_OUT <= 1'h0;
      WAKE_PHASE_OUT <= `PHASE_ZERO;
      WAKE_SEQ_ACTIVE_OUT <= `WAKE_SEQ_DEFAULT_INTERNAL;
    end else begin
      GLOBAL_OUTPUT_ENABLE_OUT <= oe_released_reg;
      GLOBAL_WRITE_INHIBIT_OUT <= ~wi_released_reg;
      GLOBAL_SET_RESET_OUT <= ~sr_released_reg;
      USER_MODE_OUT <= (state_reg == wake_pkg::ST_USER);
      WAKE_PHASE_OUT <= phase_reg;
      WAKE_SEQ_ACTIVE_OUT <= seq_reg;
    end
  end

  // Completion pin: pulled low until released, then floated for open drain
  // or driven high for push-pull. Driving low from reset tells chained
  // parts that this device is not ready.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      COMPLETION_PIN_OUT <= 1'h0;
      COMPLETION_PIN_OE_OUT <= 1'h1;
    end else if (!pin_released_reg) begin
      COMPLETION_PIN_OUT <= 1'h0;
      COMPLETION_PIN_OE_OUT <= 1'h1;
    end else if (opt_reg.completion_pin_open_drain) begin
      COMPLETION_PIN_OUT <= 1'h0;
      COMPLETION_PIN_OE_OUT <= 1'h0;
    end else begin
      COMPLETION_PIN_OUT <= 1'h1;
      COMPLETION_PIN_OE_OUT <= 1'h1;
    end
  end

  // Readback gate: each request pulse answers one cycle later with a grant
  // or a refusal. The identification area is outside the lock.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      RB_CONFIG_PORT_GRANT_OUT <= 1'h0;
      RB_JTAG_GRANT_OUT <= 1'h0;
      RB_ID_GRANT_OUT <= 1'h0;
      RB_REFUSED_OUT <= 1'h0;
    end else begin
      RB_CONFIG_PORT_GRANT_OUT <= RB_CONFIG_PORT_REQ_IN &
                                  ~opt_reg.readback_lock_option;
      RB_JTAG_GRANT_OUT <= RB_JTAG_REQ_IN & ~opt_reg.readback_lock_option;
      RB_ID_GRANT_OUT <= RB_ID_REQ_IN;
      RB_REFUSED_OUT <= (RB_CONFIG_PORT_REQ_IN | RB_JTAG_REQ_IN) &
                        opt_reg.readback_lock_option;
    end
  end

  // Input buffers: with shutoff on, only used inputs stay enabled. This
  // limits boundary scan, which the board test plan must allow for.
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      INPUT_BUF_EN_OUT <= '1;
    end else if (opt_reg.unused_input_shutoff) begin
      INPUT_BUF_EN_OUT <= INPUT_USED_IN;
    end else begin
      INPUT_BUF_EN_OUT <= '1;
    end
  end

endmodule // wake_sequencer

// ### dv/wake_sequencer_properties.sv
// Checker for the wake-up sequencer, bound to the ports of its top module.
// Assumes one system clock and a synchronous active-low reset.
`timescale 1ns/1ps
module wake_sequencer_properties #(
  parameter int NUM_INPUTS = 8
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [NUM_INPUTS-1:0] INPUT_USED_IN,
  input wire logic RB_CONFIG_PORT_REQ_IN,
  input wire logic RB_JTAG_REQ_IN,
  input wire logic RB_ID_REQ_IN,
  input wire logic COMPLETION_PIN_OE_OUT,
  input wire logic GLOBAL_OUTPUT_ENABLE_OUT,
  input wire logic GLOBAL_WRITE_INHIBIT_OUT,
  input wire logic GLOBAL_SET_RESET_OUT,
  input wire logic USER_MODE_OUT,
  input wire logic [1:0] WAKE_PHASE_OUT,
  input wire logic [4:0] WAKE_SEQ_ACTIVE_OUT,
  input wire logic RB_CONFIG_PORT_GRANT_OUT,
  input wire logic RB_ID_GRANT_OUT,
  input wire logic RB_REFUSED_OUT,
  input wire logic [NUM_INPUTS-1:0] INPUT_BUF_EN_OUT
);
  // All checks share the system clock, so one default suffices.
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  chk_reset_values: assert property ($rose(RST_N_IN) |-> GLOBAL_SET_RESET_OUT
    && GLOBAL_WRITE_INHIBIT_OUT && !GLOBAL_OUTPUT_ENABLE_OUT && !USER_MODE_OUT)
    else $error("outputs not at reset values");
  chk_id_grant: assert property (RB_ID_REQ_IN |=> RB_ID_GRANT_OUT)
    else $error("id readback not granted");
  chk_rb_answer: assert property (RB_CONFIG_PORT_REQ_IN |=>
    (RB_CONFIG_PORT_GRANT_OUT || RB_REFUSED_OUT)) else $error("readback unanswered");
  chk_refuse_source: assert property (RB_REFUSED_OUT |->
    ($past(RB_CONFIG_PORT_REQ_IN) || $past(RB_JTAG_REQ_IN))) else $error("bad refusal");
  chk_seq_range: assert property (WAKE_SEQ_ACTIVE_OUT inside {[5'h01:5'h19]})
    else $error("active sequence out of range");
  chk_oe_sticky: assert property (GLOBAL_OUTPUT_ENABLE_OUT |=> GLOBAL_OUTPUT_ENABLE_OUT)
    else $error("output enable dropped");
  chk_phase_step: assert property ($changed(WAKE_PHASE_OUT) && WAKE_PHASE_OUT != 2'h0
    |-> WAKE_PHASE_OUT == $past(WAKE_PHASE_OUT) + 2'h1) else $error("phase skipped");
  chk_phase_hold: assert property ($changed(WAKE_PHASE_OUT) |=> $stable(WAKE_PHASE_OUT))
    else $error("phase shorter than a tick");
  chk_user_release: assert property ($rose(USER_MODE_OUT) |-> ##[0:2]
    (GLOBAL_OUTPUT_ENABLE_OUT && !GLOBAL_WRITE_INHIBIT_OUT && !GLOBAL_SET_RESET_OUT))
    else $error("user mode before release");
  chk_buf_used: assert property ($stable(INPUT_USED_IN) |->
    (INPUT_BUF_EN_OUT & INPUT_USED_IN) == INPUT_USED_IN) else $error("used buffer off");

  // Main scenarios worth seeing at least once.
  cov_user: cover property ($rose(USER_MODE_OUT));
  cov_refused: cover property (RB_REFUSED_OUT);
  cov_pin_float: cover property ($fell(COMPLETION_PIN_OE_OUT));
endmodule // wake_sequencer_properties

bind wake_sequencer wake_sequencer_properties #(.NUM_INPUTS(NUM_INPUTS)) chk_i (
  .SYS_CLK_IN(SYS_CLK_IN),
  .RST_N_IN(RST_N_IN),
  .INPUT_USED_IN(INPUT_USED_IN),
  .RB_CONFIG_PORT_REQ_IN(RB_CONFIG_PORT_REQ_IN),
  .RB_JTAG_REQ_IN(RB_JTAG_REQ_IN),
  .RB_ID_REQ_IN(RB_ID_REQ_IN),
  .COMPLETION_PIN_OE_OUT(COMPLETION_PIN_OE_OUT),
  .GLOBAL_OUTPUT_ENABLE_OUT(GLOBAL_OUTPUT_ENABLE_OUT),
  .GLOBAL_WRITE_INHIBIT_OUT(GLOBAL_WRITE_INHIBIT_OUT),
  .GLOBAL_SET_RESET_OUT(GLOBAL_SET_RESET_OUT),
  .USER_MODE_OUT(USER_MODE_OUT),
  .WAKE_PHASE_OUT(WAKE_PHASE_OUT),
  .WAKE_SEQ_ACTIVE_OUT(WAKE_SEQ_ACTIVE_OUT),
  .RB_CONFIG_PORT_GRANT_OUT(RB_CONFIG_PORT_GRANT_OUT),
  .RB_ID_GRANT_OUT(RB_ID_GRANT_OUT),
  .RB_REFUSED_OUT(RB_REFUSED_OUT),
  .INPUT_BUF_EN_OUT(INPUT_BUF_EN_OUT));

// ### dv/wake_partner.sv
// Far side: the start-up clock sources and the shared completion pin.
// Assumes a pull-up on the pin and chained devices that may hold it low.
`timescale 1ns/1ps
module wake_partner (
  input wire logic clk_in,
  input wire logic pin_out_in,
  input wire logic pin_oe_in,
  output logic cfg_clk_out,
  output logic jtag_clk_out,
  output logic user_clk_out,
  output logic pin_level_out
);
  logic hold_low; // A chained device that is still busy holds the pin low.

  // Clocks stand still low between pulses.
  initial begin
    cfg_clk_out = 1'h0;
    jtag_clk_out = 1'h0;
    user_clk_out = 1'h0;
    hold_low = 1'h0;
  end

  // Pull-up wins unless some party drives the pin low.
  assign pin_level_out = !(hold_low || (pin_oe_in && !pin_out_in));

  // One slow period on the chosen source: 0 port, 1 JTAG, 2 user.
  task automatic pulse(input int src);
    @(negedge clk_in);
    if (src == 0) cfg_clk_out = 1'h1;
    if (src == 1) jtag_clk_out = 1'h1;
    if (src == 2) user_clk_out = 1'h1;
    repeat (4) @(negedge clk_in);
    cfg_clk_out = 1'h0;
    jtag_clk_out = 1'h0;
    user_clk_out = 1'h0;
    repeat (4) @(negedge clk_in);
  endtask
endmodule // wake_partner

// ### dv/wake_sequencer_tb.sv
// Self-checking bench for the wake-up sequencer with its far-side model.
// Assumes the bound checker; inputs change on falling clock edges.
`timescale 1ns/1ps
module wake_sequencer_tb;
  logic clk, rst_n, done, via_jtag, user_att, lock, wait_on, od, shut;
  logic rb_cfg, rb_jtag, rb_id, pin_o, pin_oe, global_output_enable, gwd, global_set_reset, user_m, rej;
  logic g_cfg, g_jtag, g_id, refused;
  logic [4:0] sel, seq;
  logic [1:0] phase;
  logic [7:0] used, buf_en;
  logic cfg_clk, jtag_clk, user_clk, pin_lvl;
  int err_count = 0;
  int checks_done = 0;

  wake_partner p (.clk_in(clk), .pin_out_in(pin_o), .pin_oe_in(pin_oe),
    .cfg_clk_out(cfg_clk), .jtag_clk_out(jtag_clk), .user_clk_out(user_clk),
    .pin_level_out(pin_lvl));

  wake_sequencer #(.NUM_INPUTS(8)) uut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .CONFIG_DONE_IN(done), .LOADED_VIA_JTAG_IN(via_jtag),
    .USER_CLOCK_ATTACHED_IN(user_att), .CONFIG_PORT_CLOCK_IN(cfg_clk),
    .JTAG_CLOCK_IN(jtag_clk), .USER_STARTUP_CLOCK_IN(user_clk),
    .WAKE_SEQ_SELECT_IN(sel), .READBACK_LOCK_OPTION_IN(lock),
    .EXTERNAL_COMPLETION_WAIT_IN(wait_on), .COMPLETION_PIN_OPEN_DRAIN_IN(od),
    .UNUSED_INPUT_SHUTOFF_IN(shut), .INPUT_USED_IN(used), .COMPLETION_PIN_IN(pin_lvl),
    .RB_CONFIG_PORT_REQ_IN(rb_cfg), .RB_JTAG_REQ_IN(rb_jtag), .RB_ID_REQ_IN(rb_id),
    .COMPLETION_PIN_OUT(pin_o), .COMPLETION_PIN_OE_OUT(pin_oe),
    .GLOBAL_OUTPUT_ENABLE_OUT(global_output_enable), .GLOBAL_WRITE_INHIBIT_OUT(gwd),
    .GLOBAL_SET_RESET_OUT(global_set_reset), .USER_MODE_OUT(user_m), .WAKE_PHASE_OUT(phase),
    .WAKE_SEQ_ACTIVE_OUT(seq), .WAKE_SEQ_REJECTED_OUT(rej),
    .RB_CONFIG_PORT_GRANT_OUT(g_cfg), .RB_JTAG_GRANT_OUT(g_jtag),
    .RB_ID_GRANT_OUT(g_id), .RB_REFUSED_OUT(refused), .INPUT_BUF_EN_OUT(buf_en));

  // Free-running 250 MHz system clock.
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // Compare one value and count the outcome.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch at %0t: %s", $time, m);
      err_count++;
    end
  endtask

  // Print the counts and the verdict, then end the run.
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Enable, inhibit and set/reset as one three-bit value.
  task automatic ctl(input logic [2:0] exp, input string m);
    chk({5'h00, global_output_enable, gwd, global_set_reset}, {5'h00, exp}, m);
  endtask

  // Pin enable and level as one two-bit value.
  task automatic pin(input logic [1:0] exp, input string m);
    chk({6'h00, pin_oe, pin_o}, {6'h00, exp}, m);
  endtask

  // Reset for 4 cycles with new options, then signal configuration done.
  task automatic start(input logic [4:0] s, input logic w, j, u, l, o, h,
      input logic [7:0] us);
    @(negedge clk);
    rst_n = 1'h0;
    done = 1'h0;
    {sel, wait_on, via_jtag, user_att, lock, od, shut, used} = {s, w, j, u, l, o, h, us};
    repeat (4) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    done = 1'h1;
    repeat (3) @(negedge clk);
  endtask

  // One-cycle readback request; the answer stands in the following cycle.
  task automatic rb(input logic c, j, i);
    @(negedge clk);
    {rb_cfg, rb_jtag, rb_id} = {c, j, i};
    @(negedge clk);
    {rb_cfg, rb_jtag, rb_id} = 3'h0;
  endtask

  // Bounded wait for user mode.
  task automatic wait_user();
    for (int i = 0; i < 20; i++) begin
      if (user_m === 1'h1) return;
      @(negedge clk);
    end
    chk(8'h00, 8'h01, "no user mode");
    stop_test();
  endtask

  // Reset values, and readback open with the lock option captured off.
  task automatic t_reset();
    start(5'h00, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 8'h0F);
    ctl(3'h3, "reset controls");
    pin(2'h2, "reset pin");
    chk({3'h0, seq}, 8'h15, "reset seq");
    chk(buf_en, 8'hFF, "reset buffers");
    rb(1'h1, 1'h0, 1'h0);
    chk({7'h00, g_cfg}, 8'h01, "unlocked grant");
  endtask

  // Default sequence on the port clock, pin held low but ignored, lock on.
  task automatic t_seq21();
    start(5'h00, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 8'h0F);
    p.hold_low = 1'h1;
    chk({2'h0, rej, seq}, 8'h15, "default 21");
    p.pulse(0);
    ctl(3'h3, "phase zero");
    chk({6'h00, phase}, 8'h01, "phase index");
    p.pulse(0);
    ctl(3'h7, "phase one");
    p.pulse(0);
    ctl(3'h4, "phase two");
    pin(2'h2, "pin early");
    p.pulse(0);
    pin(2'h3, "pin released");
    wait_user();
    rb(1'h1, 1'h0, 1'h0);
    chk({6'h00, refused, g_cfg}, 8'h02, "port locked");
    rb(1'h0, 1'h1, 1'h0);
    chk({6'h00, refused, g_jtag}, 8'h02, "jtag locked");
    rb(1'h0, 1'h0, 1'h1);
    chk({6'h00, refused, g_id}, 8'h01, "id open");
    p.hold_low = 1'h0;
  endtask

  // Waiting on the pin, paced by JTAG, selection out of range.
  task automatic t_wait();
    start(5'h09, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 8'h0F);
    p.hold_low = 1'h1;
    chk({2'h0, rej, seq}, 8'h24, "default 4");
    p.pulse(1);
    chk({7'h00, pin_oe}, 8'h00, "pin floats");
    p.pulse(1);
    p.pulse(1);
    ctl(3'h3, "held by pin");
    p.hold_low = 1'h0;
    repeat (3) @(negedge clk);
    p.pulse(0);
    ctl(3'h3, "port clock ignored");
    p.pulse(1);
    ctl(3'h7, "phase one");
    p.pulse(1);
    ctl(3'h4, "phase two");
    p.pulse(1);
    wait_user();
  endtask

  // User clock overrides, sequence 25, unused buffers shut off.
  task automatic t_user();
    start(5'h19, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 8'h5A);
    chk({2'h0, rej, seq}, 8'h19, "seq 25");
    p.pulse(0);
    p.pulse(1);
    p.pulse(2);
    p.pulse(2);
    ctl(3'h6, "user clock phase one");
    p.pulse(2);
    ctl(3'h4, "user clock phase two");
    p.pulse(2);
    chk({7'h00, pin_oe}, 8'h00, "open drain release");
    chk(buf_en, 8'h5A, "unused shut off");
    wait_user();
  endtask

  // Range edges with and without the wait.
  task automatic t_bounds();
    start(5'h1A, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'h0F);
    chk({2'h0, rej, seq}, 8'h35, "26 refused");
    start(5'h07, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'h0F);
    chk({2'h0, rej, seq}, 8'h07, "7 accepted");
    start(5'h01, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'h0F);
    chk({2'h0, rej, seq}, 8'h01, "1 accepted");
  endtask

  // Main sequence.
  initial begin
    {rst_n, done, via_jtag, user_att, lock, wait_on, od, shut} = 8'h00;
    {rb_cfg, rb_jtag, rb_id, sel, used} = {3'h0, 5'h00, 8'h0F};
    t_reset();
    t_seq21();
    t_wait();
    t_user();
    t_bounds();
    stop_test();
  end
endmodule // wake_sequencer_tb
